// ### tdc_map.svh
// Constants for the triple down-counter timers
`ifndef TDC_MAP_SVH
`define TDC_MAP_SVH

// =========================================
// Counter geometry and reset values
`define TDC_NUM_TIMERS 3
`define TDC_CNT_W      16
`define TDC_WRAP_VAL   16'hffff
`define TDC_RST_CNT    16'h0000
`define TDC_RST_LOAD   16'h0000

// =========================================
// Timer indices and source selection
`define TDC_FAST_IDX   2
`define TDC_SEL_508K   1'b0
`define TDC_SEL_2K     1'b1

`endif

// ### tdc_pkg.sv
// Types shared by the triple down-counter timers
`include "tdc_map.svh"
`default_nettype none

package tdc_pkg;

  typedef logic [`TDC_CNT_W-1:0] tdc_cnt_t;

  // Per-timer configuration bits
  typedef struct packed {
    logic enable;
    logic periodic;
    logic clk_sel;
  } tdc_cfg_t;

  // Per-timer software access strobes
  typedef struct packed {
    logic     load_wr;
    logic     clear_wr;
    tdc_cnt_t data;
  } tdc_wr_t;

endpackage

`default_nettype wire

// ### tdc_timers.sv
// Three 16-bit down-counting timers with underflow interrupts
`include "tdc_map.svh"
`default_nettype none

// Overview of operation
// [RULE1] Two identical timers, each with a 16-bit data register and control bits.
// [RULE2] Writing a timer's data register loads the counter at once.
// [RULE3] The first two timers decrement on the next selected source edge after a write.
// [RULE4] Underflow raises that timer's interrupt in the same cycle.
// [RULE5] Every count is readable at any time without disturbing it.
// [RULE6] First two timers select 508 kHz or 2 kHz counting source.
// [RULE7] The third timer counts only from the fixed 7.3728 MHz source.
// [RULE8] Third timer has load, value, control and clear registers.
// [RULE9] Enabled third timer decrements on the next fast-clock rising edge after a write.
// [RULE10] Each timer runs free-running or periodic, chosen by a control bit.
// [RULE11] Free-running underflow wraps the count to 0xffff.
// [RULE12] Periodic underflow reloads the last written value.
// [RULE13] Any write to a clear register drops that timer's pending interrupt; here an underflow in the same cycle keeps it set.
// [RULE14] A disabled timer holds its count and raises no interrupt.
module tdc_timers
(
  // Clock and reset
  input  wire logic                                       clock,
  input  wire logic                                       rst_n,
  // Counting source pins
  input  wire logic                                       src_508k_pin,
  input  wire logic                                       src_2k_pin,
  input  wire logic                                       src_fast_pin,
  // Software control and access
  input  wire tdc_pkg::tdc_cfg_t [`TDC_NUM_TIMERS-1:0]    cfg,
  input  wire tdc_pkg::tdc_wr_t  [`TDC_NUM_TIMERS-1:0]    wr,
  // Counts and interrupts
  output var  tdc_pkg::tdc_cnt_t [`TDC_NUM_TIMERS-1:0]    count,
  output var  logic              [`TDC_NUM_TIMERS-1:0]    irq
);

  // =========================================
  // Source synchronisers and edge detect
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic [2:0] sync1_d;
  logic [2:0] sync2_d;
  logic [2:0] prev_d;
  logic [2:0] rise;

  // Sources are asynchronous to clock, so two flops before any edge logic
  always_comb
  begin
    sync1_d = {src_fast_pin, src_2k_pin, src_508k_pin};
    sync2_d = sync1_q;
    prev_d  = sync2_q;
    rise    = sync2_q & ~prev_q;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      prev_q  <= 3'h0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
    end
  end

  // =========================================
  // Tick selection
  logic [`TDC_NUM_TIMERS-1:0] tick;

  // Picks the counting edge for one timer from the three detected edges
  function automatic logic pick_tick(
    input int         idx,
    input logic       sel,
    input logic [2:0] edges
  );
    logic res;
    if (idx == `TDC_FAST_IDX)
      res = edges[2];                                       // [RULE7]
    else if (sel == `TDC_SEL_2K)
      res = edges[1];                                       // [RULE6]
    else
      res = edges[0];                                       // [RULE6]
    return res;
  endfunction

  always_comb
  begin
    for (int i = 0; i < `TDC_NUM_TIMERS; i++)
    begin
      tick[i] = pick_tick(i, cfg[i].clk_sel, rise);
    end
  end

  // =========================================
  // Load registers
  tdc_pkg::tdc_cnt_t [`TDC_NUM_TIMERS-1:0] load_q;
  tdc_pkg::tdc_cnt_t [`TDC_NUM_TIMERS-1:0] load_d;

  // Last written value stays as the periodic reload source
  always_comb
  begin
    for (int i = 0; i < `TDC_NUM_TIMERS; i++)
    begin
      if (wr[i].load_wr)
        load_d[i] = wr[i].data;                             // [RULE1] [RULE8]
      else
        load_d[i] = load_q[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `TDC_NUM_TIMERS; i++)
      begin
        load_q[i] <= `TDC_RST_LOAD;
      end
    end
    else
    begin
      load_q <= load_d;
    end
  end

  // =========================================
  // Counters
  tdc_pkg::tdc_cnt_t [`TDC_NUM_TIMERS-1:0] cnt_q;
  tdc_pkg::tdc_cnt_t [`TDC_NUM_TIMERS-1:0] cnt_d;
  logic              [`TDC_NUM_TIMERS-1:0] step;
  logic              [`TDC_NUM_TIMERS-1:0] under;

  // True when a tick at this count is an underflow
  function automatic logic at_bottom(
    input tdc_pkg::tdc_cnt_t cur
  );
    return (cur == `TDC_RST_CNT);
  endfunction

  // Next count on a tick: decrement, or wrap/reload at underflow
  function automatic tdc_pkg::tdc_cnt_t next_count(
    input tdc_pkg::tdc_cnt_t cur,
    input tdc_pkg::tdc_cnt_t reload,
    input logic              periodic
  );
    tdc_pkg::tdc_cnt_t res;
    if (cur != `TDC_RST_CNT)
      res = cur - 16'h0001;
    else if (periodic)
      res = reload;                                         // [RULE12]
    else
      res = `TDC_WRAP_VAL;                                  // [RULE11]
    return res;
  endfunction

  always_comb
  begin
    for (int i = 0; i < `TDC_NUM_TIMERS; i++)
    begin
      // Disabled timers ignore source edges; a write drops a same-cycle tick
      step[i]  = cfg[i].enable && tick[i] && !wr[i].load_wr;  // [RULE14]
      under[i] = step[i] && at_bottom(cnt_q[i]);
      if (wr[i].load_wr)
        cnt_d[i] = wr[i].data;                              // [RULE2] [RULE3] [RULE9]
      else if (step[i])
        cnt_d[i] = next_count(cnt_q[i], load_q[i], cfg[i].periodic); // [RULE10]
      else
        cnt_d[i] = cnt_q[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `TDC_NUM_TIMERS; i++)
      begin
        cnt_q[i] <= `TDC_RST_CNT;
      end
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // =========================================
  // Underflow interrupts
  logic [`TDC_NUM_TIMERS-1:0] irq_q;
  logic [`TDC_NUM_TIMERS-1:0] irq_d;

  always_comb
  begin
    for (int i = 0; i < `TDC_NUM_TIMERS; i++)
    begin
      // Set beats a clear in the same cycle so no underflow is lost
      if (under[i])
        irq_d[i] = 1'b1;                                    // [RULE4]
      else if (wr[i].clear_wr)
        irq_d[i] = 1'b0;                                    // [RULE13]
      else
        irq_d[i] = irq_q[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      irq_q <= 3'h0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  // =========================================
  // Outputs straight from flops; reading never touches the count
  always_comb
  begin
    count = cnt_q;                                          // [RULE5]
    irq   = irq_q;
  end

endmodule

`default_nettype wire

// ### tdc_sva.sv
// Assertions for the three timers
`include "tdc_map.svh"
`default_nettype none
module tdc_sva
(
  // Watched ports
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic                    src_fast_pin,
  input wire tdc_pkg::tdc_cfg_t [2:0] cfg,
  input wire tdc_pkg::tdc_wr_t  [2:0] wr,
  input wire tdc_pkg::tdc_cnt_t [2:0] count,
  input wire logic              [2:0] irq
);
  // ====
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_load_now: assert property (wr[0].load_wr |=> count[0] == $past(wr[0].data))
    else $error("load");
  a_irq_under: assert property ($rose(irq[0]) |-> $past(count[0]) == 16'h0)
    else $error("irq");
  a_wrap_free: assert property ($rose(irq[0]) && !$past(cfg[0].periodic) |-> count[0] == 16'hffff)
    else $error("wrap");
  a_irq_keep: assert property (irq[1] && !wr[1].clear_wr |=> irq[1])
    else $error("keep");
  a_clear_drop: assert property (wr[0].clear_wr && count[0] != 16'h0 |=> !irq[0])
    else $error("clear");
  a_hold_off: assert property (!cfg[2].enable && !wr[2].load_wr |=> $stable(count[2]) && !$rose(irq[2]))
    else $error("hold");
  a_step_one: assert property (!wr[0].load_wr && count[0] != 16'h0 |=>
    count[0] == $past(count[0]) || count[0] == $past(count[0]) - 16'h1)
    else $error("step");
  // Fast source needs two synchroniser flops before a tick lands
  a_fast_tick: assert property ($rose(src_fast_pin) && cfg[2].enable && count[2] != 16'h0 &&
    !wr[2].load_wr |-> ##[1:6] count[2] != $past(count[2]))
    else $error("fast");
endmodule
bind tdc_timers tdc_sva u_sva (.clock, .rst_n, .src_fast_pin, .cfg, .wr, .count, .irq);
`default_nettype wire

// ### triple_down_counter_timers_tb.sv
// Bench for the three timers
`include "tdc_map.svh"
`default_nettype none
module triple_down_counter_timers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clock = 1'b0;
  logic                     rst_n = 1'b0;
  logic              [2:0]  src = 3'h0;
  tdc_pkg::tdc_cfg_t [2:0]  cfg = '0;
  tdc_pkg::tdc_wr_t  [2:0]  wr = '0;
  tdc_pkg::tdc_cnt_t [2:0]  count;
  logic              [2:0]  irq;
  int                       bad_count = 0;
  int                       check_count = 0;
  int                       cyc = 0;
  logic              [33:0] rows [3] = '{{2'h0, 16'hffff, 16'hffff}, {2'h1, 16'h0, 16'h0},
    {2'h2, 16'h1234, 16'h1234}};
  tdc_timers uut (.clock, .rst_n, .src_508k_pin(src[0]), .src_2k_pin(src[1]),
    .src_fast_pin(src[2]), .cfg, .wr, .count, .irq);
  // ====
  // Clock, limit and helpers
  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic wrt(input int i, input logic [15:0] d, input logic c);
    @(negedge clock);
    wr[i] = {~c, c, d};
    @(negedge clock);
    wr[i] = '0;
  endtask
  // Pin held 3 cycles so the synchroniser sees one edge
  task automatic tk(input int b);
    @(negedge clock);
    src[b] = 1'b1;
    repeat (3) @(negedge clock);
    src[b] = 1'b0;
    repeat (4) @(negedge clock);
  endtask
  task automatic results;
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clock);
    chk(count[0], 16'h0);
    rst_n = 1'b1;
    foreach (rows[k])
    begin
      wrt(rows[k][33:32], rows[k][31:16], 1'b0);
      chk(count[rows[k][33:32]], rows[k][15:0]);
    end
    cfg[0] = 3'b100;
    wrt(0, 16'h1, 1'b0);
    tk(0);
    chk(count[0], 16'h0);
    tk(0);
    chk(count[0], 16'hffff);
    chk({13'h0, irq}, 16'h1);
    tk(1);
    chk(count[0], 16'hffff);
    wrt(0, 16'h0, 1'b1);
    chk({13'h0, irq}, 16'h0);
    cfg[1] = 3'b111;
    wrt(1, 16'h1, 1'b0);
    tk(1);
    tk(1);
    chk(count[1], 16'h1);
    chk({13'h0, irq}, 16'h2);
    wrt(2, 16'h5, 1'b0);
    tk(2);
    chk(count[2], 16'h5);
    cfg[2] = 3'b101;
    tk(2);
    chk(count[2], 16'h4);
    tk(1);
    chk(count[2], 16'h4);
    wrt(2, 16'h0, 1'b0);
    tk(2);
    chk(count[2], 16'hffff);
    chk({13'h0, irq}, 16'h6);
    wrt(2, 16'h0, 1'b1);
    chk({13'h0, irq}, 16'h2);
    // Mid-run reset must clear counts and pending interrupts
    rst_n = 1'b0;
    repeat (3) @(negedge clock);
    chk(count[2], 16'h0);
    chk({13'h0, irq}, 16'h0);
    rst_n = 1'b1;
    results();
  end
endmodule
`default_nettype wire
